// ---- design/osc_clock_ctrl.sv ----
// Clock source supervision, clock switching and power-on reset sequencing
// Overview of operation
// - Low-power RC clock feeds watchdog and monitor; power-up timer counts clock_i; selectable as clock.
// - Low-power RC runs from reset; afterwards only if monitor, watchdog or selected.
// - With monitor enabled, low-power RC runs except in Sleep, ignoring soft enable.
// - Oscillator failure raises a trap and moves the system clock to fast RC.
// - Failure loads current group with fast RC, sets fail flag, clears go bit.
// - Watchdog keeps counting on the low-power RC after a clock failure.
// - Monitor traps if oscillator not ready when reset timers expire.
// - Four source groups; switch only between groups; primary option from configuration.
// - Current group read-only, new group writable; both load from configuration on power-on and brown-out reset.
// - Go bit set starts a switch; clearing it aborts the switch.
// - Control register shows PLL lock and clock-fail status.
// - Switch-monitor select 1x disables switching and monitor; this is default.
// - With switching off, configuration selects clock; current group only mirrors it.
// - Low byte writable one cycle after key writes 0x46 then 0x57.
// - High byte writable one cycle after key writes 0x78 then 0x9A.
// - Reset causes are told apart and recorded in status bits.
// - Watchdog wake-up only sets the sleep and watchdog cause bits and is no reset.
// - Master clear filters short pulses; internal resets never drive that pin.
// - Power-on and brown-out reset wait fixed 10 us then 0, 4, 16 or 64 ms delay.
// - After both delays reset releases on next first-quarter phase edge.
// - Without monitor and timer, exit quickly; hold in reset until clock starts.
// - Crystal modes count 1024 oscillator cycles before passing the clock.
// - Group value 001 denotes the fast internal RC clock.
`timescale 1ns/100ps
`include "osc_defs.svh"
module osc_clock_ctrl #(
  parameter int PWRT4_CYC = `OSC_POWER_UP_TIMER_4_MS * `OSC_CLK_MHZ * 1000,
  parameter int PWRT16_CYC = `OSC_POWER_UP_TIMER_16_MS * `OSC_CLK_MHZ * 1000,
  parameter int PWRT64_CYC = `OSC_POWER_UP_TIMER_64_MS * `OSC_CLK_MHZ * 1000
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wr_be_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Configuration fuses
  input wire osc_pkg::osc_cfg_t cfg_i,
  // Oscillator status
  input wire logic low_power_rc_osc_tick_i,
  input wire logic sys_clk_edge_i,
  input wire logic osc_running_i,
  input wire logic osc_cycle_i,
  input wire logic pll_lock_i,
  input wire logic new_grp_ready_i,
  input wire logic first_quarter_phase_i,
  // Reset and power events
  input wire logic brown_out_reset_i,
  input wire logic master_clear_pin_n_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic wdt_timeout_i,
  input wire logic wdt_wake_i,
  input wire logic reset_instr_i,
  input wire logic trap_lockup_reset_i,
  input wire logic illegal_op_reset_i,
  input wire logic soft_watchdog_enable_i,
  // Clock and reset outputs
  output logic low_power_rc_osc_enable_o,
  output logic wdt_tick_o,
  output logic [2:0] cur_group_o,
  output logic [4:0] primary_mode_o,
  output logic sys_clk_gate_o,
  output logic clock_fail_trap_o,
  output logic internal_system_reset_o
);
  import osc_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  logic [2:0] current_osc_group_r;
  logic [2:0] new_osc_group_r;
  logic swgo_r;
  logic cf_r;
  logic low_power_rc_osc_en_r;
  logic ost_done_r;
  logic gate_r;
  logic fail_r;
  logic [10:0] ost_cnt_r;
  logic [2:0] win_r;
  logic [21:0] cnt_r;
  logic [15:0] rdata_r;
  osc_seq_t seq_r;
  osc_cause_t cause_r;
  osc_key_t key_r [2];
  logic master_clear_pin_n;
  logic master_clear_pin_q_r;
  logic sw_en;
  logic fail_safe_monitor_en;
  logic crystal;
  logic start_bad;
  logic fail_evt;
  logic soft_rst;
  logic [21:0] power_up_timer_tgt;
  logic [1:0] bwr;
  logic [1:0] open_wr;
  logic [15:0] ctrl_rd;

  osc_master_clear_pin_filter u_master_clear_pin_filter (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .pin_n_i(master_clear_pin_n_i),
    .filt_n_o(master_clear_pin_n)
  );

  assign sw_en = !cfg_i.switch_monitor_select[1];
  assign fail_safe_monitor_en = (cfg_i.switch_monitor_select == 2'b00);
  assign soft_rst = !master_clear_pin_n || wdt_timeout_i || reset_instr_i
                    || trap_lockup_reset_i || illegal_op_reset_i;

  always_comb begin
    unique case (cfg_i.primary_mode_config)
      5'h00, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07,
      5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17: crystal = 1'b1;
      default: crystal = 1'b0;
    endcase
    crystal = crystal && (current_osc_group_r == 3'h3 || current_osc_group_r == `OSC_GRP_PLL);
  end

  always_comb begin
    unique case (cfg_i.power_up_timer_sel)
      2'd0: power_up_timer_tgt = 22'h0;
      2'd1: power_up_timer_tgt = 22'(PWRT4_CYC);
      2'd2: power_up_timer_tgt = 22'(PWRT16_CYC);
      2'd3: power_up_timer_tgt = 22'(PWRT64_CYC);
    endcase
  end

  // Reset sequencing: fixed delay, power-up delay, quarter phase
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= RS_POR_FIXED_DELAY;
      cnt_r <= 22'h0;
    end else if (brown_out_reset_i) begin
      seq_r <= RS_POR_FIXED_DELAY;
      cnt_r <= 22'h0;
    end else if (soft_rst) begin
      seq_r <= RS_Q1;
      cnt_r <= 22'h0;
    end else begin
      unique case (seq_r)
        RS_POR_FIXED_DELAY: begin
          if (cnt_r == 22'(`OSC_POR_FIXED_DELAY_CYC - 1)) begin
            cnt_r <= 22'h0;
            seq_r <= RS_POWER_UP_TIMER;
          end else begin
            cnt_r <= cnt_r + 22'h1;
          end
        end
        RS_POWER_UP_TIMER: begin
          if (power_up_timer_tgt == 22'h0 || cnt_r == power_up_timer_tgt - 22'h1) begin
            cnt_r <= 22'h0;
            seq_r <= RS_Q1;
          end else begin
            cnt_r <= cnt_r + 22'h1;
          end
        end
        RS_Q1: begin
          // Without the monitor, stay in reset until the clock runs
          if (first_quarter_phase_i && (fail_safe_monitor_en || osc_running_i)) begin
            seq_r <= RS_RUN;
          end
        end
        RS_RUN: begin
          seq_r <= RS_RUN;
        end
      endcase
    end
  end

  assign internal_system_reset_o = (seq_r != RS_RUN);

  // Low-power RC enable
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      low_power_rc_osc_en_r <= 1'b1;
    end else begin
      low_power_rc_osc_en_r <= (seq_r != RS_RUN)
                   || (fail_safe_monitor_en && !sleep_i)
                   || cfg_i.wdt_cfg_en
                   || (soft_watchdog_enable_i && !fail_safe_monitor_en)
                   || (current_osc_group_r == `OSC_GRP_LOW_POWER_RC_OSC);
    end
  end

  assign low_power_rc_osc_enable_o = low_power_rc_osc_en_r;
  assign wdt_tick_o = low_power_rc_osc_tick_i && low_power_rc_osc_en_r;

  // Start-up timer on crystal oscillators
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ost_cnt_r <= 11'h0;
      ost_done_r <= 1'b0;
    end else if (brown_out_reset_i || wake_i) begin
      ost_cnt_r <= 11'h0;
      ost_done_r <= 1'b0;
    end else if (osc_cycle_i && !ost_done_r) begin
      ost_cnt_r <= ost_cnt_r + 11'h1;
      ost_done_r <= (ost_cnt_r == `OSC_OST_CYCLES - 11'h1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= ost_done_r || !crystal;
    end
  end

  assign sys_clk_gate_o = gate_r;

  // Fail-safe monitor: missing clock edges or a late start
  assign start_bad = !osc_running_i || (crystal && !ost_done_r)
                     || (current_osc_group_r == `OSC_GRP_PLL && !pll_lock_i);
  assign fail_evt = fail_safe_monitor_en && current_osc_group_r != `OSC_GRP_FRC && !sleep_i
                    && ((seq_r == RS_Q1 && first_quarter_phase_i && start_bad
                         && !soft_rst && !brown_out_reset_i)
                        || (seq_r == RS_RUN && win_r == `OSC_FAIL_SAFE_MONITOR_WIN));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      win_r <= 3'h0;
    end else if (sys_clk_edge_i || fail_evt || !fail_safe_monitor_en || sleep_i) begin
      win_r <= 3'h0;
    end else if (low_power_rc_osc_tick_i && win_r != `OSC_FAIL_SAFE_MONITOR_WIN) begin
      win_r <= win_r + 3'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fail_r <= 1'b0;
    end else begin
      fail_r <= fail_evt;
    end
  end

  assign clock_fail_trap_o = fail_r;

  // Unlock sequence per byte of the control register
  for (genvar b = 0; b < 2; b++) begin : g_key
    localparam logic [7:0] K1 = (b == 0) ? `OSC_KEY_LO1 : `OSC_KEY_HI1;
    localparam logic [7:0] K2 = (b == 0) ? `OSC_KEY_LO2 : `OSC_KEY_HI2;
    logic [7:0] wbyte;
    assign wbyte = wdata_i[8*b +: 8];
    assign bwr[b] = wr_be_i[b] && addr_i == `OSC_REG_CTRL;
    assign open_wr[b] = bwr[b] && key_r[b] == KEY_OPEN;
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        key_r[b] <= KEY_IDLE;
      end else if (bwr[b] && key_r[b] == KEY_FIRST && wbyte == K2) begin
        key_r[b] <= KEY_OPEN;
      end else if (bwr[b] && key_r[b] != KEY_OPEN && wbyte == K1) begin
        key_r[b] <= KEY_FIRST;
      end else begin
        key_r[b] <= KEY_IDLE;
      end
    end
  end

  // Group selection and switch sequence
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      current_osc_group_r <= 3'h0;
      new_osc_group_r <= 3'h0;
      swgo_r <= 1'b0;
      cf_r <= 1'b0;
    end else if (seq_r == RS_POR_FIXED_DELAY) begin
      current_osc_group_r <= cfg_i.osc_group_config;
      new_osc_group_r <= cfg_i.osc_group_config;
      swgo_r <= 1'b0;
      cf_r <= 1'b0;
    end else if (fail_evt) begin
      current_osc_group_r <= `OSC_GRP_FRC;
      cf_r <= 1'b1;
      swgo_r <= 1'b0;
    end else if (!sw_en) begin
      current_osc_group_r <= cfg_i.osc_group_config;
      swgo_r <= 1'b0;
    end else begin
      if (open_wr[1]) begin
        new_osc_group_r <= wdata_i[`OSC_CTRL_NEW_OSC_GROUP +: 3];
      end
      if (open_wr[0]) begin
        swgo_r <= wdata_i[`OSC_CTRL_SWGO];
      end else if (swgo_r && current_osc_group_r == new_osc_group_r) begin
        swgo_r <= 1'b0;
      end else if (swgo_r && new_grp_ready_i) begin
        current_osc_group_r <= new_osc_group_r;
        swgo_r <= 1'b0;
      end
    end
  end

  assign cur_group_o = current_osc_group_r;
  assign primary_mode_o = cfg_i.primary_mode_config;

  // Reset cause bits, set wins over a software write
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= osc_cause_t'(`OSC_CAUSE_RST);
    end else begin
      osc_cause_t set_v;
      set_v = '0;
      set_v.bor = brown_out_reset_i;
      set_v.ext = !master_clear_pin_n && master_clear_pin_q_r;
      set_v.sleep = (!master_clear_pin_n && master_clear_pin_q_r && sleep_i) || wdt_wake_i;
      set_v.wdt = wdt_timeout_i || wdt_wake_i;
      set_v.sw = reset_instr_i;
      set_v.trap_lockup_reset = trap_lockup_reset_i;
      set_v.illegal_op_reset = illegal_op_reset_i;
      if (wr_be_i[0] && addr_i == `OSC_REG_CAUSE) begin
        cause_r <= osc_cause_t'(wdata_i[7:0]) | set_v;
      end else begin
        cause_r <= cause_r | set_v;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_q_r <= 1'b1;
    end else begin
      master_clear_pin_q_r <= master_clear_pin_n;
    end
  end

  // Read port
  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`OSC_CTRL_CURRENT_OSC_GROUP +: 3] = current_osc_group_r;
    ctrl_rd[`OSC_CTRL_NEW_OSC_GROUP +: 3] = new_osc_group_r;
    ctrl_rd[`OSC_CTRL_LOCK] = pll_lock_i;
    ctrl_rd[`OSC_CTRL_CF] = cf_r;
    ctrl_rd[`OSC_CTRL_SWGO] = swgo_r;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (rd_i && addr_i == `OSC_REG_CTRL) begin
      rdata_r <= ctrl_rd;
    end else if (rd_i && addr_i == `OSC_REG_CAUSE) begin
      rdata_r <= {8'h00, cause_r};
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata_o = rdata_r;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence s_lo_keys;
    bwr[0] && wdata_i[7:0] == `OSC_KEY_LO1 ##1 bwr[0] && wdata_i[7:0] == `OSC_KEY_LO2;
  endsequence
  sequence s_hi_keys;
    bwr[1] && wdata_i[15:8] == `OSC_KEY_HI1 ##1 bwr[1] && wdata_i[15:8] == `OSC_KEY_HI2;
  endsequence

  chk_fail_frc_switch: assert property (
    fail_evt |=> current_osc_group_r == `OSC_GRP_FRC && cf_r && !swgo_r && clock_fail_trap_o)
    else $error("failure did not move clock to fast RC");
  chk_low_power_rc_osc_in_reset: assert property (
    seq_r != RS_RUN |=> low_power_rc_osc_enable_o)
    else $error("low-power RC off during reset sequence");
  chk_low_power_rc_osc_monitor_on: assert property (
    fail_safe_monitor_en && !sleep_i |=> low_power_rc_osc_enable_o)
    else $error("low-power RC off with monitor enabled");
  chk_wdt_tick_run: assert property (
    low_power_rc_osc_tick_i && low_power_rc_osc_en_r |-> wdt_tick_o)
    else $error("watchdog tick lost");
  chk_lo_key_open: assert property (
    s_lo_keys ##1 !bwr[0] |=> !open_wr[0] && key_r[0] == KEY_IDLE)
    else $error("low byte stayed open past one cycle");
  chk_hi_key_open: assert property (
    s_hi_keys |=> key_r[1] == KEY_OPEN)
    else $error("high byte not opened by key pair");
  chk_key_wrong_reset: assert property (
    bwr[0] && key_r[0] == KEY_FIRST && wdata_i[7:0] != `OSC_KEY_LO2 |=> key_r[0] != KEY_OPEN)
    else $error("wrong key opened low byte");
  chk_cfg_direct_sel: assert property (
    !sw_en && seq_r != RS_POR_FIXED_DELAY |=> cur_group_o == $past(cfg_i.osc_group_config))
    else $error("group does not follow configuration");
  chk_q1_release: assert property (
    seq_r == RS_Q1 ##0 (first_quarter_phase_i && osc_running_i && !soft_rst
    && !brown_out_reset_i) |=> !internal_system_reset_o [*2])
    else $error("reset not released on quarter phase");
endmodule // osc_clock_ctrl

// ---- design/osc_defs.svh ----
// Offsets, fields, reset values and timing counts of the clock control block
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
`define OSC_CLK_MHZ 50
`define OSC_LOW_POWER_RC_OSC_KHZ 512
`define OSC_POR_FIXED_DELAY_US 10
`define OSC_POR_FIXED_DELAY_CYC (`OSC_POR_FIXED_DELAY_US * `OSC_CLK_MHZ)
`define OSC_POWER_UP_TIMER_4_MS 4
`define OSC_POWER_UP_TIMER_16_MS 16
`define OSC_POWER_UP_TIMER_64_MS 64
`define OSC_MASTER_CLEAR_PIN_FILT_NS 200
`define OSC_MASTER_CLEAR_PIN_FILT_CYC ((`OSC_MASTER_CLEAR_PIN_FILT_NS * `OSC_CLK_MHZ + 999) / 1000)
`define OSC_OST_CYCLES 11'h400
`define OSC_FAIL_SAFE_MONITOR_WIN 3'h4
`define OSC_REG_CTRL 4'h0
`define OSC_REG_CAUSE 4'h4
`define OSC_CTRL_CURRENT_OSC_GROUP 12
`define OSC_CTRL_NEW_OSC_GROUP 8
`define OSC_CTRL_LOCK 5
`define OSC_CTRL_CF 3
`define OSC_CTRL_SWGO 0
`define OSC_GRP_SEC 3'h0
`define OSC_GRP_FRC 3'h1
`define OSC_GRP_LOW_POWER_RC_OSC 3'h2
`define OSC_GRP_PLL 3'h7
`define OSC_KEY_LO1 8'h46
`define OSC_KEY_LO2 8'h57
`define OSC_KEY_HI1 8'h78
`define OSC_KEY_HI2 8'h9A
`define OSC_CAUSE_RST 8'h03
`endif

// ---- design/osc_pkg.sv ----
// Types shared by the clock control block
package osc_pkg;
  typedef struct packed {
    logic [2:0] osc_group_config;
    logic [4:0] primary_mode_config;
    logic [1:0] switch_monitor_select;
    logic [1:0] power_up_timer_sel;
    logic wdt_cfg_en;
  } osc_cfg_t;
  typedef struct packed {
    logic illegal_op_reset;
    logic trap_lockup_reset;
    logic ext;
    logic sw;
    logic wdt;
    logic sleep;
    logic por;
    logic bor;
  } osc_cause_t;
  typedef enum logic [1:0] {RS_POR_FIXED_DELAY, RS_POWER_UP_TIMER, RS_Q1, RS_RUN} osc_seq_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_OPEN} osc_key_t;
endpackage

// ---- design/osc_master_clear_pin_filter.sv ----
// Noise filter for the master clear pin
`timescale 1ns/100ps
`include "osc_defs.svh"
module osc_master_clear_pin_filter (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Pin level and filtered level
  input wire logic pin_n_i,
  output logic filt_n_o
);
  localparam int FILT_CYC = `OSC_MASTER_CLEAR_PIN_FILT_CYC;
  logic [7:0] cnt_r;

  // Level must hold for the whole filter time before it is accepted
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      filt_n_o <= 1'b1;
    end else if (pin_n_i == filt_n_o) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(FILT_CYC - 1)) begin
      cnt_r <= 8'h00;
      filt_n_o <= pin_n_i;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // osc_master_clear_pin_filter

// ---- design/osc_unused_placeholder_none.sv ----
// Intentionally empty
`timescale 1ns/100ps

// ---- bench/osc_src_model.sv ----
// Behavioural model of the oscillators that feed the clock control block
`timescale 1ns/100ps
module osc_src_model (
  // Clock and test controls
  input wire logic clock_i,
  input wire logic stall_i,
  input wire logic lock_i,
  // Oscillator status towards the block
  output logic low_power_rc_osc_tick_o,
  output logic sys_clk_edge_o,
  output logic osc_running_o,
  output logic osc_cycle_o,
  output logic pll_lock_o,
  output logic new_grp_ready_o,
  output logic first_quarter_phase_o
);
  logic [3:0] cnt_r = 4'h0;
  always_ff @(posedge clock_i) begin
    cnt_r <= cnt_r + 4'h1;
  end
  // Low-power RC tick every eighth cycle
  assign low_power_rc_osc_tick_o = (cnt_r[2:0] == 3'h0);
  // Source stays far above the monitor floor unless stalled
  assign sys_clk_edge_o = ~stall_i & cnt_r[0];
  assign osc_cycle_o = ~stall_i;
  assign osc_running_o = ~stall_i;
  assign pll_lock_o = lock_i;
  // Requested source always ready, so a switch completes at once
  assign new_grp_ready_o = 1'b1;
  assign first_quarter_phase_o = (cnt_r[1:0] == 2'h3);
endmodule // osc_src_model

// ---- bench/osc_clock_ctrl_tb.sv ----
// Self-checking testbench of the clock control block
`timescale 1ns/100ps
`include "osc_defs.svh"
module osc_clock_ctrl_tb;
  import osc_pkg::*;
  logic clock_i, arst_n_i, rd_i, master_clear_pin_n, stall, lock, sleep, wdt_wake;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [1:0] wr_be_i;
  logic [4:0] ev;
  osc_cfg_t cfg;
  logic tick, edge_s, run, cyc, plk, rdy, q1;
  logic low_power_rc_osc_en, wdt_tick, gate, trap, internal_system_reset;
  logic [2:0] cur_grp;
  logic [4:0] pmode;
  int error_cnt = 0;
  int comparisons = 0;

  osc_src_model osc_src_model_i (.clock_i(clock_i), .stall_i(stall), .lock_i(lock),
    .low_power_rc_osc_tick_o(tick), .sys_clk_edge_o(edge_s), .osc_running_o(run), .osc_cycle_o(cyc),
    .pll_lock_o(plk), .new_grp_ready_o(rdy), .first_quarter_phase_o(q1));

  osc_clock_ctrl #(.PWRT4_CYC(20), .PWRT16_CYC(40), .PWRT64_CYC(80)) osc_clock_ctrl_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_be_i(wr_be_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_i(cfg),
    .low_power_rc_osc_tick_i(tick), .sys_clk_edge_i(edge_s), .osc_running_i(run), .osc_cycle_i(cyc),
    .pll_lock_i(plk), .new_grp_ready_i(rdy), .first_quarter_phase_i(q1),
    .brown_out_reset_i(ev[4]), .master_clear_pin_n_i(master_clear_pin_n), .sleep_i(sleep),
    .wake_i(1'b0), .wdt_timeout_i(ev[0]), .wdt_wake_i(wdt_wake), .reset_instr_i(ev[1]),
    .trap_lockup_reset_i(ev[2]), .illegal_op_reset_i(ev[3]), .soft_watchdog_enable_i(1'b0),
    .low_power_rc_osc_enable_o(low_power_rc_osc_en), .wdt_tick_o(wdt_tick), .cur_group_o(cur_grp),
    .primary_mode_o(pmode), .sys_clk_gate_o(gate), .clock_fail_trap_o(trap),
    .internal_system_reset_o(internal_system_reset));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, e);
  endtask

  // Three writes in consecutive cycles: two key bytes, then the data
  task automatic wr3(input logic [3:0] a, input logic [1:0] be, input logic [7:0] k1,
                     input logic [7:0] k2, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_be_i <= be;
    wdata_i <= {k1, k1};
    @(posedge clock_i);
    wdata_i <= {k2, k2};
    @(posedge clock_i);
    wdata_i <= d;
    @(posedge clock_i);
    wr_be_i <= 2'h0;
  endtask

  task automatic wait_rel(input int min);
    int n;
    n = 0;
    while (internal_system_reset !== 1'b0 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    // Let flops launched on this edge settle before callers look
    #1;
    chk(16'(n >= min), 16'h1);
    chk(16'(n < 3000), 16'h1);
  endtask

  task automatic power_up(input osc_cfg_t c, input int power_up_timer);
    @(posedge clock_i);
    cfg <= c;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    wait_rel(500 + power_up_timer);
  endtask

  task automatic t_switch;
    power_up('{3'h1, 5'h0C, 2'h0, 2'h1, 1'b0}, 20);
    chk(16'(cur_grp), 16'h1);
    rchk(4'h0, 16'h7729, 16'h1120);
    lock <= 1'b0;
    rchk(4'h0, 16'h0020, 16'h0000);
    lock <= 1'b1;
    wr3(4'h0, 2'h1, 8'h00, 8'h00, 16'h0001);
    rchk(4'h0, 16'h7729, 16'h1120);
    wr3(4'h0, 2'h2, `OSC_KEY_HI1, `OSC_KEY_HI2, 16'h0200);
    rchk(4'h0, 16'h7729, 16'h1220);
    wr3(4'h0, 2'h1, `OSC_KEY_LO1, 8'h99, 16'h0001);
    rchk(4'h0, 16'h7729, 16'h1220);
    wr3(4'h0, 2'h1, `OSC_KEY_LO1, `OSC_KEY_LO2, 16'h0001);
    rchk(4'h0, 16'h7729, 16'h2220);
    chk(16'(cur_grp), 16'h2);
    chk(16'(low_power_rc_osc_en), 16'h1);
    $display("test switch done, mismatches %0d", error_cnt);
  endtask

  task automatic t_fail;
    int n;
    n = 0;
    @(posedge clock_i);
    stall <= 1'b1;
    while (trap !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    chk(16'(n <= 48), 16'h1);
    @(posedge clock_i);
    #1 chk(16'(trap), 16'h0);
    chk(16'(cur_grp), 16'h1);
    rchk(4'h0, 16'h7009, 16'h1008);
    n = 0;
    repeat (64) begin
      @(posedge clock_i);
      #1 n += int'(wdt_tick === 1'b1);
    end
    chk(16'(n), 16'h8);
    chk(16'(low_power_rc_osc_en), 16'h1);
    stall <= 1'b0;
    $display("test fail done, mismatches %0d", error_cnt);
  endtask

  task automatic t_causes;
    logic [7:0] exp [5] = '{8'h08, 8'h10, 8'h40, 8'h80, 8'h01};
    int n;
    wr3(4'h4, 2'h1, 8'h00, 8'h00, 16'h0000);
    @(posedge clock_i);
    wdt_wake <= 1'b1;
    @(posedge clock_i);
    wdt_wake <= 1'b0;
    rchk(4'h4, 16'h00FF, 16'h000C);
    chk(16'(internal_system_reset), 16'h0);
    for (int i = 0; i < 5; i++) begin
      wr3(4'h4, 2'h1, 8'h00, 8'h00, 16'h0000);
      ev <= 5'(1 << i);
      @(posedge clock_i);
      ev <= 5'h0;
      n = 0;
      while (internal_system_reset !== 1'b1 && n < 20) begin
        @(posedge clock_i);
        n++;
      end
      chk(16'(internal_system_reset), 16'h1);
      wait_rel((i == 4) ? 520 : 0);
      rchk(4'h4, 16'h00FF, 16'(exp[i]));
    end
    chk(16'(cur_grp), 16'h1);
    for (int s = 0; s < 2; s++) begin
      wr3(4'h4, 2'h1, 8'h00, 8'h00, 16'h0000);
      sleep <= s[0];
      master_clear_pin_n <= 1'b0;
      repeat (3) @(posedge clock_i);
      master_clear_pin_n <= 1'b1;
      repeat (15) @(posedge clock_i);
      chk(16'(internal_system_reset), 16'h0);
      master_clear_pin_n <= 1'b0;
      repeat (20) @(posedge clock_i);
      chk(16'(internal_system_reset), 16'h1);
      master_clear_pin_n <= 1'b1;
      sleep <= 1'b0;
      wait_rel(0);
      rchk(4'h4, 16'h00FF, (s == 0) ? 16'h0020 : 16'h0024);
    end
    $display("test causes done, mismatches %0d", error_cnt);
  endtask

  task automatic t_noswitch;
    int n;
    power_up('{3'h3, 5'h0C, 2'h2, 2'h3, 1'b0}, 80);
    chk(16'(cur_grp), 16'h3);
    chk(16'(pmode), 16'h000C);
    chk(16'(low_power_rc_osc_en), 16'h0);
    wr3(4'h0, 2'h2, `OSC_KEY_HI1, `OSC_KEY_HI2, 16'h0100);
    wr3(4'h0, 2'h1, `OSC_KEY_LO1, `OSC_KEY_LO2, 16'h0001);
    repeat (4) @(posedge clock_i);
    chk(16'(cur_grp), 16'h3);
    stall <= 1'b1;
    n = 0;
    repeat (100) begin
      @(posedge clock_i);
      #1 n += int'(trap === 1'b1);
    end
    chk(16'(n), 16'h0);
    stall <= 1'b0;
    $display("test noswitch done, mismatches %0d", error_cnt);
  endtask

  initial begin
    arst_n_i = 1'b0;
    rd_i = 1'b0;
    wr_be_i = 2'h0;
    addr_i = 4'h0;
    wdata_i = 16'h0;
    master_clear_pin_n = 1'b1;
    stall = 1'b0;
    lock = 1'b1;
    sleep = 1'b0;
    wdt_wake = 1'b0;
    ev = 5'h0;
    cfg = '{3'h1, 5'h0C, 2'h0, 2'h1, 1'b0};
    t_switch();
    t_fail();
    t_causes();
    t_noswitch();
    give_verdict();
  end

  initial begin
    #(20 * 40000);
    error_cnt++;
    give_verdict();
  end
endmodule // osc_clock_ctrl_tb
